//--- design/link_policy_pkg.sv
// shared constants and types for the display link lane and clock policy block
package link_policy_pkg;

   // lane layout
   localparam int BYTE_W = 8;
   localparam int LANE_W = 2;
   localparam int NUM_LANES = 4;
   localparam logic [2:0] LANES_MIN = 3'h1;
   localparam logic [2:0] LANES_MAX = 3'h4;
   localparam logic [LANE_W-1:0] LANE_ZERO = 2'h0;

   // clock period of the byte-clock domain, in ns
   localparam int CLK_PERIOD_NS = 10;

   // nominal peripheral escape clock period, host may sit at 67% to 150% of its rate
   localparam int ESC_NOM_NS = 100;
   localparam int ESC_NOM_CYC = ESC_NOM_NS / CLK_PERIOD_NS;
   localparam int ESC_MIN_CYC = (ESC_NOM_CYC * 2) / 3;
   localparam int ESC_MAX_CYC = (ESC_NOM_CYC * 3) / 2;
   localparam int ESC_CNT_W = 5;

   // self-clocked flush time after a low-power transfer ends
   localparam int LP_DRAIN_NS = 50;
   localparam int LP_DRAIN_CYC = (LP_DRAIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DRAIN_W = 4;

   // one received byte with its lane and signalling mode
   typedef struct packed {
      logic [BYTE_W-1:0] data;
      logic hs;
      logic [LANE_W-1:0] lane;
   } rx_byte_t;

   // sticky error and advisory flags
   typedef struct packed {
      logic cfg_err;
      logic lane_err;
      logic clk_err;
      logic early_err;
      logic deskew_err;
      logic deskew_untrig;
      logic esc_ratio_err;
   } status_t;

   // kind of reverse message the peripheral sends
   typedef enum logic [1:0] {
      REPLY_DATA,
      REPLY_ACK,
      REPLY_TE
   } reply_kind_t;

   // bus ownership as seen by the peripheral
   typedef enum logic [1:0] {
      DIR_FWD,
      DIR_PREP,
      DIR_REPLY
   } dir_state_t;

endpackage : link_policy_pkg

//--- design/reverse_lp_sender.sv
// low-power reverse byte sender on lane 0 with final bus handover
module reverse_lp_sender
   import link_policy_pkg::*;
(
   input wire logic clk_i,                      // byte clock
   input wire logic sys_rst_i,                  // sync reset, high
   input wire logic en_i,                       // peripheral owns the bus
   input wire logic resp_valid_i,               // app byte offered
   input wire logic [BYTE_W-1:0] resp_data_i,   // app byte
   input wire reply_kind_t resp_kind_i,         // message kind
   input wire logic resp_last_i,                // last byte of reply
   output logic resp_ready_o,                   // slot free
   input wire logic phy_ready_i,                // phy took byte
   output logic tx_valid_o,                     // byte to phy
   output logic [BYTE_W-1:0] tx_data_o,         // byte value
   output reply_kind_t tx_kind_o,               // byte kind
   output logic handover_o,                     // one-cycle hand back
   output logic te_sent_o                       // te trigger went out
);

   logic last_q;
   logic done_q;

   // one-byte slot; ready is registered so it never depends on the app combinationally
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         tx_valid_o <= 1'b0;
         tx_data_o <= '0;
         tx_kind_o <= REPLY_DATA;
         last_q <= 1'b0;
         resp_ready_o <= 1'b0;
         handover_o <= 1'b0;
         done_q <= 1'b0;
         te_sent_o <= 1'b0;
      end else begin
         handover_o <= 1'b0;
         te_sent_o <= 1'b0;
         if (resp_ready_o && resp_valid_i) begin
            tx_valid_o <= 1'b1;
            tx_data_o <= resp_data_i;
            tx_kind_o <= resp_kind_i;
            last_q <= resp_last_i;
            resp_ready_o <= 1'b0;
         end else if (tx_valid_o && phy_ready_i) begin
            tx_valid_o <= 1'b0;
            handover_o <= last_q;
            te_sent_o <= (tx_kind_o == REPLY_TE);
            done_q <= last_q;
            resp_ready_o <= en_i && !last_q;
         end else begin
            done_q <= done_q && en_i;
            resp_ready_o <= en_i && !tx_valid_o && !done_q;
         end
      end
   end

endmodule : reverse_lp_sender

//--- design/esc_ratio_check.sv
// checks the host escape clock period against the peripheral's own
module esc_ratio_check
   import link_policy_pkg::*;
(
   input wire logic clk_i,        // byte clock
   input wire logic sys_rst_i,    // sync reset, high
   input wire logic lp_active_i,  // escape transfer running
   input wire logic esc_edge_i,   // recovered escape clock edge
   output logic err_o             // sticky ratio violation
);

   localparam logic [ESC_CNT_W-1:0] CNT_MIN = ESC_CNT_W'(ESC_MIN_CYC);
   localparam logic [ESC_CNT_W-1:0] CNT_MAX = ESC_CNT_W'(ESC_MAX_CYC);
   localparam logic [ESC_CNT_W-1:0] CNT_TOP = '1;

   logic [ESC_CNT_W-1:0] cnt_q;
   logic seen_q;

   // period counter, saturating so a long pause reads as too slow
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || !lp_active_i) begin
         cnt_q <= '0;
         seen_q <= 1'b0;
      end else if (esc_edge_i) begin
         cnt_q <= 5'h01;
         seen_q <= 1'b1;
      end else if (cnt_q != CNT_TOP) begin
         cnt_q <= cnt_q + 5'h01;
      end
   end

   // only whole periods between two edges are judged
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         err_o <= 1'b0;
      end else if (lp_active_i && esc_edge_i && seen_q && (cnt_q < CNT_MIN || cnt_q > CNT_MAX)) begin
         err_o <= 1'b1;
      end
   end

endmodule : esc_ratio_check

//--- design/display_link_policy.sv
// peripheral side lane, direction and clock policy for the display serial link
module display_link_policy
   import link_policy_pkg::*;
(
   input wire logic clk_i,                           // byte clock, 100 MHz
   input wire logic sys_rst_i,                       // sync reset, high
   input wire logic cfg_video_mode_i,                // 1 video, 0 command
   input wire logic cfg_lane0_bidir_i,               // lane 0 may turn in video
   input wire logic [2:0] cfg_lane_count_i,          // data lanes in use
   input wire logic cfg_deskew_used_i,               // link uses de-skew
   input wire rx_byte_t phy_rx_i,                    // received byte
   input wire logic phy_rx_valid_i,                  // byte strobe
   input wire logic phy_start_of_burst_i,            // burst begins
   input wire logic phy_end_of_burst_i,              // burst ends
   input wire logic phy_lp_active_i,                 // low-power transfer running
   input wire logic phy_reversal_i,                  // reversal command seen
   input wire logic phy_trigger_i,                   // trigger received
   input wire logic [LANE_W-1:0] phy_trigger_lane_i, // lane of trigger
   input wire logic phy_te_oob_i,                    // out-of-band te line
   input wire logic phy_clk_hs_i,                    // clock lane toggling
   input wire logic phy_clk_stop_i,                  // clock lane in stop state
   input wire logic phy_deskew_i,                    // de-skew pattern running
   input wire logic phy_esc_edge_i,                  // escape clock edge
   input wire logic phy_tx_ready_i,                  // phy took reverse byte
   input wire logic app_resp_valid_i,                // reply byte offered
   input wire logic [BYTE_W-1:0] app_resp_data_i,    // reply byte
   input wire reply_kind_t app_resp_kind_i,          // reply kind
   input wire logic app_resp_last_i,                 // last reply byte
   output logic app_resp_ready_o,                    // reply byte taken
   output rx_byte_t app_rx_o,                        // byte to protocol
   output logic app_rx_valid_o,                      // byte strobe
   output logic app_rx_end_o,                        // burst end strobe
   output logic app_handover_o,                      // direction_handover indication
   output logic [BYTE_W-1:0] app_last_cmd_o,         // first byte of last burst
   output logic phy_tx_valid_o,                      // reverse byte strobe
   output logic [BYTE_W-1:0] phy_tx_data_o,          // reverse byte
   output reply_kind_t phy_tx_kind_o,                // reverse byte kind
   output logic phy_tx_hs_o,                         // reverse high-speed, held low
   output logic direction_handover_request_o,        // hand bus back
   output logic [NUM_LANES-1:0] lane_oe_o,           // data lane drive enables
   output logic clk_lane_oe_o,                       // clock lane drive, held low
   output dir_state_t dir_state_o,                   // bus ownership
   output logic clk_continuous_o,                    // clock never stopped outside a burst
   output logic lp_drain_busy_o,                     // flushing low-power data
   output status_t status_o                          // sticky flags
);

   dir_state_t dir_q;
   dir_state_t dir_d;
   logic burst_q;
   logic first_q;
   logic deskew_done_q;
   logic te_seen_q;
   logic handover_pulse;
   logic te_sent;
   logic esc_err;
   logic lp_active_q;
   logic [DRAIN_W-1:0] drain_q;
   logic lane0_turns;
   logic cfg_bad;
   logic lane_bad;
   logic clk_bad;
   logic deskew_bad;
   logic sender_en;

   // flush length counted on our own clock
   localparam logic [DRAIN_W-1:0] DRAIN_LOAD = DRAIN_W'(LP_DRAIN_CYC);

   // lane 0 may turn round in command mode always, in video mode by choice
   assign lane0_turns = !cfg_video_mode_i || cfg_lane0_bidir_i;

   // lane count must lie in the documented range
   assign cfg_bad = (cfg_lane_count_i < LANES_MIN) || (cfg_lane_count_i > LANES_MAX);

   // forward low-power bytes and triggers belong on lane 0; unused lanes stay silent
   assign lane_bad = (phy_rx_valid_i && !phy_rx_i.hs && phy_rx_i.lane != LANE_ZERO)
                  || (phy_trigger_i && phy_trigger_lane_i != LANE_ZERO)
                  || (phy_rx_valid_i && {1'b0, phy_rx_i.lane} >= cfg_lane_count_i);

   // a high-speed byte needs the clock lane toggling
   assign clk_bad = phy_rx_valid_i && phy_rx_i.hs && !phy_clk_hs_i;

   // de-skew must not land in a burst, in a turnaround or with a stopped clock
   assign deskew_bad = phy_deskew_i && (burst_q || phy_start_of_burst_i
                                        || dir_q != DIR_FWD
                                        || !phy_clk_hs_i);

   // the sender may only talk while the bus is ours
   assign sender_en = (dir_q == DIR_REPLY);

   // receive path: no ready toward the phy, every byte is taken the cycle it arrives
   // a stall here would break a burst, so none exists
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         app_rx_o <= '0;
         app_rx_valid_o <= 1'b0;
         app_rx_end_o <= 1'b0;
      end else begin
         app_rx_valid_o <= phy_rx_valid_i;
         app_rx_end_o <= phy_end_of_burst_i;
         if (phy_rx_valid_i) begin
            app_rx_o <= phy_rx_i;
         end
      end
   end

   // burst tracking and capture of the command that picks the reply
   // later bytes of a burst are payload only
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         burst_q <= 1'b0;
         first_q <= 1'b0;
         app_last_cmd_o <= '0;
      end else begin
         if (phy_start_of_burst_i) begin
            burst_q <= 1'b1;
            first_q <= 1'b1;
         end else if (phy_end_of_burst_i) begin
            burst_q <= 1'b0;
         end
         if (phy_rx_valid_i && (first_q || phy_start_of_burst_i)) begin
            app_last_cmd_o <= phy_rx_i.data;
            first_q <= 1'b0;
         end
      end
   end

   // flush time after low-power data stops; runs on our own clock, not the host's
   // a new transfer inside the flush simply restarts it
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         lp_active_q <= 1'b0;
         drain_q <= '0;
         lp_drain_busy_o <= 1'b0;
      end else begin
         lp_active_q <= phy_lp_active_i;
         if (lp_active_q && !phy_lp_active_i) begin
            drain_q <= DRAIN_LOAD;
         end else if (drain_q != '0) begin
            drain_q <= drain_q - 4'h1;
         end
         lp_drain_busy_o <= phy_lp_active_i || (drain_q > 4'h1) || (lp_active_q && !phy_lp_active_i);
      end
   end

   // next bus owner
   // a refused reversal leaves the bus with the host
   always_comb begin
      dir_d = dir_q;
      case (dir_q)
         DIR_FWD: begin
            if (phy_reversal_i && lane0_turns) begin
               dir_d = DIR_PREP;
            end
         end
         DIR_PREP: begin
            if (app_resp_valid_i) begin
               dir_d = DIR_REPLY;
            end
         end
         DIR_REPLY: begin
            if (handover_pulse) begin
               dir_d = DIR_FWD;
            end
         end
         default: begin
            dir_d = DIR_FWD;
         end
      endcase
   end

   // ownership state and lane drive; the clock lane is never ours to drive
   // upper lanes never turn, so only bit 0 can rise
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         dir_q <= DIR_FWD;
         dir_state_o <= DIR_FWD;
         lane_oe_o <= '0;
         clk_lane_oe_o <= 1'b0;
         phy_tx_hs_o <= 1'b0;
         app_handover_o <= 1'b0;
      end else begin
         dir_q <= dir_d;
         dir_state_o <= dir_d;
         lane_oe_o <= {3'h0, dir_d != DIR_FWD};
         clk_lane_oe_o <= 1'b0;
         phy_tx_hs_o <= 1'b0;
         app_handover_o <= (dir_q == DIR_FWD) && (dir_d == DIR_PREP);
      end
   end

   // reverse escape sender on lane 0
   reverse_lp_sender u_sender (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .en_i(sender_en),
      .resp_valid_i(app_resp_valid_i),
      .resp_data_i(app_resp_data_i),
      .resp_kind_i(app_resp_kind_i),
      .resp_last_i(app_resp_last_i),
      .resp_ready_o(app_resp_ready_o),
      .phy_ready_i(phy_tx_ready_i),
      .tx_valid_o(phy_tx_valid_o),
      .tx_data_o(phy_tx_data_o),
      .tx_kind_o(phy_tx_kind_o),
      .handover_o(handover_pulse),
      .te_sent_o(te_sent)
   );

   // a registered one-cycle pulse from the sender
   assign direction_handover_request_o = handover_pulse;

   // escape clock ratio watch
   // judged only while an escape transfer runs
   esc_ratio_check u_esc (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .lp_active_i(phy_lp_active_i),
      .esc_edge_i(phy_esc_edge_i),
      .err_o(esc_err)
   );

   // clock mode: continuous is always handled, a stop between bursts is tolerated
   // a stop inside a burst is left to the clock check
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         clk_continuous_o <= 1'b1;
      end else if (phy_clk_stop_i && !burst_q) begin
         clk_continuous_o <= 1'b0;
      end
   end

   // de-skew bookkeeping; a te trigger arms the next periodic pass
   // the initial pass is never judged against te
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         deskew_done_q <= 1'b0;
         te_seen_q <= 1'b0;
      end else begin
         if (phy_deskew_i) begin
            deskew_done_q <= 1'b1;
         end
         if (te_sent || phy_te_oob_i) begin
            te_seen_q <= 1'b1;
         end else if (phy_deskew_i) begin
            te_seen_q <= 1'b0;
         end
      end
   end

   // sticky flags; they only clear under reset so a short event is never lost
   // the untriggered flag is advisory and stops nothing
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         status_o <= '0;
      end else begin
         if (cfg_bad || (phy_reversal_i && !lane0_turns)) begin
            status_o.cfg_err <= 1'b1;
         end
         if (lane_bad) begin
            status_o.lane_err <= 1'b1;
         end
         if (clk_bad) begin
            status_o.clk_err <= 1'b1;
         end
         if (phy_start_of_burst_i && cfg_deskew_used_i && !deskew_done_q) begin
            status_o.early_err <= 1'b1;
         end
         if (deskew_bad) begin
            status_o.deskew_err <= 1'b1;
         end
         if (phy_deskew_i && deskew_done_q && (!te_seen_q || phy_te_oob_i)) begin
            status_o.deskew_untrig <= 1'b1;
         end
         status_o.esc_ratio_err <= esc_err;
      end
   end

endmodule : display_link_policy

//--- sim/display_link_props.sv
// concurrent checks on the display link policy block ports
module display_link_props
   import link_policy_pkg::*;
(
   input wire logic clk_i,                         // byte clock
   input wire logic sys_rst_i,                     // sync reset
   input wire logic cfg_video_mode_i,              // video mode
   input wire logic cfg_lane0_bidir_i,             // lane 0 may turn
   input wire rx_byte_t phy_rx_i,                  // received byte
   input wire logic phy_rx_valid_i,                // byte strobe
   input wire logic phy_lp_active_i,               // lp transfer
   input wire logic phy_reversal_i,                // reversal seen
   input wire logic phy_tx_ready_i,                // phy took byte
   input wire rx_byte_t app_rx_o,                  // byte out
   input wire logic app_rx_valid_o,                // byte out strobe
   input wire logic app_handover_o,                // handover pulse
   input wire logic phy_tx_valid_o,                // reverse strobe
   input wire logic [BYTE_W-1:0] phy_tx_data_o,    // reverse byte
   input wire logic phy_tx_hs_o,                   // reverse hs
   input wire logic direction_handover_request_o,  // bus back
   input wire logic [NUM_LANES-1:0] lane_oe_o,     // lane drives
   input wire logic clk_lane_oe_o,                 // clock drive
   input wire dir_state_t dir_state_o,             // ownership
   input wire logic lp_drain_busy_o,               // lp flush
   input wire status_t status_o                    // sticky flags
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);

   // a reversal that the lane setup allows, and the state it must lead to
   sequence turn_taken;
      phy_reversal_i && dir_state_o == DIR_FWD && (!cfg_video_mode_i || cfg_lane0_bidir_i);
   endsequence
   sequence prep_entered;
      app_handover_o && dir_state_o == DIR_PREP && lane_oe_o[0];
   endsequence

   clk_lane_quiet_a: assert property (!clk_lane_oe_o)
      else $error("clock lane driven by peripheral");
   reverse_lp_only_a: assert property (!phy_tx_hs_o)
      else $error("reverse byte in high speed");
   upper_lanes_fwd_a: assert property (lane_oe_o[NUM_LANES-1:1] == '0)
      else $error("upper lane driven");
   rx_pass_a: assert property (phy_rx_valid_i |=> app_rx_valid_o && app_rx_o == $past(phy_rx_i))
      else $error("received byte lost or changed");
   turn_accept_a: assert property (turn_taken |=> prep_entered)
      else $error("reversal not handed to protocol");
   turn_refuse_a: assert property (phy_reversal_i && dir_state_o == DIR_FWD && cfg_video_mode_i
      && !cfg_lane0_bidir_i |=> (!app_handover_o && dir_state_o == DIR_FWD) ##[0:1] status_o.cfg_err)
      else $error("reversal on forward lane taken");
   tx_hold_a: assert property (phy_tx_valid_o && !phy_tx_ready_i |=> phy_tx_valid_o && $stable(phy_tx_data_o))
      else $error("reverse byte dropped before taken");
   bus_return_a: assert property (direction_handover_request_o |=> dir_state_o == DIR_FWD && !lane_oe_o[0])
      else $error("bus not returned after request");
   lp_lane_err_a: assert property (phy_rx_valid_i && !phy_rx_i.hs && phy_rx_i.lane != LANE_ZERO
      |-> ##[0:2] status_o.lane_err)
      else $error("lp byte off lane zero not flagged");
   lp_drain_a: assert property ($fell(phy_lp_active_i) |-> lp_drain_busy_o [*4] ##[1:4] !lp_drain_busy_o)
      else $error("lp drain time wrong");
endmodule : display_link_props

//--- sim/host_link_model.sv
// host side model: takes reverse bytes after a chosen stall
module host_link_model
   import link_policy_pkg::*;
(
   input wire logic clk_i,                  // byte clock
   input wire logic sys_rst_i,              // sync reset
   input wire logic tx_valid_i,             // reverse byte offered
   input wire logic [BYTE_W-1:0] tx_data_i, // reverse byte
   input wire logic [3:0] wait_i,           // stall cycles
   output logic tx_ready_o,                 // byte taken
   output logic [BYTE_W-1:0] got_data_o,    // last byte taken
   output logic [7:0] got_cnt_o             // bytes taken
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_q;

   // escape-mode reception is slow, so ready comes after a stall
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || !tx_valid_i || tx_ready_o) begin
         wait_q <= 4'h0;
         tx_ready_o <= 1'b0;
      end else begin
         wait_q <= wait_q + 4'h1;
         tx_ready_o <= (wait_q >= wait_i);
      end
   end

   // capture only on a real handshake edge
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         got_cnt_o <= 8'h00;
         got_data_o <= 8'h00;
      end else if (tx_valid_i && tx_ready_o) begin
         got_cnt_o <= got_cnt_o + 8'h01;
         got_data_o <= tx_data_i;
      end
   end
endmodule : host_link_model

//--- sim/testbench.sv
// self-checking bench for the display link policy block
module testbench
   import link_policy_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic sys_rst_i, vid, bidir, dsk_use, rxv, sob, eob, lp, rev, trig, te, chs, cstop, dsk, esc, rv, rlast, ptr;
   logic rrdy, arv, aend, aho, txv, txhs, dreq, cloe, ccont, drn;
   logic [2:0] lcnt;
   logic [1:0] tlane;
   logic [3:0] pw, loe;
   logic [7:0] rd, lcmd, txd, gdat, gcnt;
   rx_byte_t rx, arx;
   reply_kind_t rk, txk;
   dir_state_t dst;
   status_t st, es;
   int bad_count, checks_done, cyc, seed;

   display_link_policy i_display_link_policy (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cfg_video_mode_i(vid),
      .cfg_lane0_bidir_i(bidir), .cfg_lane_count_i(lcnt), .cfg_deskew_used_i(dsk_use), .phy_rx_i(rx),
      .phy_rx_valid_i(rxv), .phy_start_of_burst_i(sob), .phy_end_of_burst_i(eob), .phy_lp_active_i(lp),
      .phy_reversal_i(rev), .phy_trigger_i(trig), .phy_trigger_lane_i(tlane), .phy_te_oob_i(te),
      .phy_clk_hs_i(chs), .phy_clk_stop_i(cstop), .phy_deskew_i(dsk), .phy_esc_edge_i(esc),
      .phy_tx_ready_i(ptr), .app_resp_valid_i(rv), .app_resp_data_i(rd), .app_resp_kind_i(rk),
      .app_resp_last_i(rlast), .app_resp_ready_o(rrdy), .app_rx_o(arx), .app_rx_valid_o(arv),
      .app_rx_end_o(aend), .app_handover_o(aho), .app_last_cmd_o(lcmd), .phy_tx_valid_o(txv),
      .phy_tx_data_o(txd), .phy_tx_kind_o(txk), .phy_tx_hs_o(txhs), .direction_handover_request_o(dreq),
      .lane_oe_o(loe), .clk_lane_oe_o(cloe), .dir_state_o(dst), .clk_continuous_o(ccont),
      .lp_drain_busy_o(drn), .status_o(st));
   host_link_model i_host_link_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .tx_valid_i(txv), .tx_data_i(txd),
      .wait_i(pw), .tx_ready_o(ptr), .got_data_o(gdat), .got_cnt_o(gcnt));

   // free-running byte clock
   always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;

   // hang guard, the whole run needs well under a thousand cycles
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         report_and_stop();
      end
   end

   function automatic logic esc_bad(input int g);
      return g < ESC_MIN_CYC || g > ESC_MAX_CYC;
   endfunction : esc_bad

   function automatic logic turn_ok(input logic v, input logic b);
      return !v || b;
   endfunction : turn_ok

   task tick;
      @(posedge clk_i);
      #1;
   endtask : tick

   task report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : report_and_stop

   task cmp8(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask : cmp8

   task cmp_st(input status_t g, input status_t e);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %0t flags %b want %b", $time, g, e);
      end
   endtask : cmp_st

   // high-speed burst sent back to back, no gaps allowed
   task burst(input int n);
      logic [7:0] d, first;
      first = 8'h00;
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         if (i == 0) first = d;
         rx = {d, 1'b1, i[1:0]};
         {rxv, sob} = {1'b1, i == 0};
         tick();
         cmp8(arx.data, d);
         cmp8({7'h00, arv}, 8'h01);
      end
      {rxv, sob, eob} = 3'b001;
      tick();
      eob = 1'b0;
      cmp8({7'h00, aend}, 8'h01);
      cmp8(lcmd, first);
   endtask : burst

   // three lp bytes paced by escape edges gap cycles apart
   task lp_xfer(input int gap, input logic [1:0] ln);
      lp = 1'b1;
      for (int i = 0; i < 3; i++) begin
         {esc, rxv} = 2'b11;
         rx = {8'($urandom), 1'b0, i == 2 ? ln : LANE_ZERO};
         tick();
         {esc, rxv} = 2'b00;
         repeat (gap - 1) tick();
      end
      lp = 1'b0;
      tick();
      cmp8({7'h00, drn}, 8'h01);
      repeat (12) tick();
      cmp8({7'h00, drn}, 8'h00);
      es.esc_ratio_err |= esc_bad(gap);
      es.lane_err |= (ln != LANE_ZERO);
      cmp_st(st, es);
   endtask : lp_xfer

   // reversal, reply of nb bytes of cycling kinds, bus handed back
   task turn(input int nb, input logic v, input logic b);
      logic [7:0] c0;
      logic ok;
      ok = turn_ok(v, b);
      c0 = gcnt;
      {vid, bidir, rev} = {v, b, 1'b1};
      pw = 4'($urandom_range(0, 6));
      tick();
      rev = 1'b0;
      cmp8({7'h00, aho}, {7'h00, ok});
      cmp8({6'h00, dst}, ok ? 8'h01 : 8'h00);
      es.cfg_err |= !ok;
      if (!ok) return;
      for (int i = 0; i < nb; i++) begin
         rd = 8'($urandom);
         rk = reply_kind_t'(i % 3);
         {rv, rlast} = {1'b1, i == nb - 1};
         for (int k = 0; k < 50 && !rrdy; k++) tick();
         cmp8({7'h00, rrdy}, 8'h01);
         tick();
      end
      rv = 1'b0;
      for (int k = 0; k < 99 && !dreq; k++) tick();
      cmp8({7'h00, dreq}, 8'h01);
      tick();
      cmp8({6'h00, dst}, 8'h00);
      cmp8(gcnt - c0, 8'(nb));
      cmp8(gdat, rd);
      cmp8({6'h00, txk}, {6'h00, rk});
   endtask : turn

   // de-skew pattern, with the clock lane in hs or not
   task deskew(input logic hs);
      {chs, dsk} = {hs, 1'b1};
      tick();
      {chs, dsk} = 2'b10;
      repeat (3) tick();
      es.deskew_err |= !hs;
      es.deskew_untrig |= !hs;
      cmp_st(st, es);
   endtask : deskew

   // main sequence, flags are sticky so the order of scenarios matters
   initial begin
      {vid, bidir, rxv, sob, eob, lp, rev, trig, te, cstop, dsk, esc, rv, rlast, tlane, rd, pw} = '0;
      {sys_rst_i, chs, dsk_use, lcnt, rx, rk, es} = {3'b111, LANES_MAX, 11'h000, REPLY_DATA, 7'h00};
      seed = $urandom(86087);
      repeat (6) @(posedge clk_i);
      #1 sys_rst_i = 1'b0;
      cmp8({7'h00, ccont}, 8'h01);
      cmp_st(st, es);
      burst(1);
      es.early_err = 1'b1;
      cmp_st(st, es);
      repeat (4) burst($urandom_range(2, 9));
      lp_xfer(ESC_NOM_CYC, LANE_ZERO);
      lp_xfer(ESC_MIN_CYC, LANE_ZERO);
      lp_xfer(ESC_MAX_CYC, LANE_ZERO);
      lp_xfer($urandom_range(ESC_MIN_CYC, ESC_MAX_CYC), 2'h2);
      lp_xfer(ESC_MIN_CYC - 1, LANE_ZERO);
      turn(3, 1'b0, 1'b0);
      deskew(1'b1);
      deskew(1'b0);
      turn(1, 1'b1, 1'b0);
      turn(2, 1'b1, 1'b1);
      repeat (4) turn($urandom_range(1, 4), 1'b0, 1'b0);
      // mid-run reset, then de-skew inside a turnaround
      sys_rst_i = 1'b1;
      repeat (2) tick();
      {sys_rst_i, es, rev} = 9'h001;
      cmp_st(st, es);
      tick();
      {rev, dsk} = 2'b01;
      tick();
      dsk = 1'b0;
      es.deskew_err = 1'b1;
      cmp_st(st, es);
      {chs, cstop} = 2'b01;
      repeat (2) tick();
      cmp8({7'h00, ccont}, 8'h00);
      cmp_st(st, es);
      report_and_stop();
   end
endmodule : testbench

bind display_link_policy display_link_props i_display_link_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
   .cfg_video_mode_i(cfg_video_mode_i), .cfg_lane0_bidir_i(cfg_lane0_bidir_i), .phy_rx_i(phy_rx_i),
   .phy_rx_valid_i(phy_rx_valid_i), .phy_lp_active_i(phy_lp_active_i), .phy_reversal_i(phy_reversal_i),
   .phy_tx_ready_i(phy_tx_ready_i), .app_rx_o(app_rx_o), .app_rx_valid_o(app_rx_valid_o),
   .app_handover_o(app_handover_o), .phy_tx_valid_o(phy_tx_valid_o), .phy_tx_data_o(phy_tx_data_o),
   .phy_tx_hs_o(phy_tx_hs_o), .direction_handover_request_o(direction_handover_request_o),
   .lane_oe_o(lane_oe_o), .clk_lane_oe_o(clk_lane_oe_o), .dir_state_o(dir_state_o),
   .lp_drain_busy_o(lp_drain_busy_o), .status_o(status_o));
